//--- shared/gwc_pkg.sv
// constants for the global configuration and watchdog block
// assumes a single 250 MHz clock and the 8-bit internal register port
package gwc_pkg;

  // ---------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------
  localparam int REG_W  = 8;
  localparam int ADDR_W = 8;
  localparam int TMR_W  = 36;

  // ---------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CFG_TWO   = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_CFG_THREE = 8'h02;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int BUS_WD_LSB = 6;
  localparam int LPM_BIT    = 5;
  localparam int RSVD_BIT   = 4;
  localparam int SLPC_BIT   = 3;
  localparam int EN_BIT     = 2;
  localparam int PER_LSB    = 0;
  localparam int CLR_LSB    = 0;

  // ---------------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------------
  localparam logic [1:0]       BUS_WD_RST  = 2'h0;
  localparam logic             LPM_RST     = 1'b0;
  localparam logic             SLPC_RST    = 1'b0;
  localparam logic             EN_RST      = 1'b0;
  localparam logic [1:0]       PER_RST     = 2'h3;
  localparam logic [1:0]       CLR_RST     = 2'h0;
  localparam logic [1:0]       BUS_WD_OFF  = 2'h0;
  localparam logic [1:0]       CLR_CMD     = 2'h1;
  localparam logic [1:0]       CLR_IDLE    = 2'h0;
  localparam logic [REG_W-1:0] RD_ZERO     = 8'h00;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam longint CLK_HZ        = 64'd250_000_000;
  localparam longint CLK_PERIOD_NS = 64'd4;

  localparam longint SYS_WD_T0_S = 64'd2;
  localparam longint SYS_WD_T1_S = 64'd16;
  localparam longint SYS_WD_T2_S = 64'd64;
  localparam longint SYS_WD_T3_S = 64'd128;
  localparam longint SYS_WD_CYC0 = SYS_WD_T0_S * CLK_HZ;
  localparam longint SYS_WD_CYC1 = SYS_WD_T1_S * CLK_HZ;
  localparam longint SYS_WD_CYC2 = SYS_WD_T2_S * CLK_HZ;
  localparam longint SYS_WD_CYC3 = SYS_WD_T3_S * CLK_HZ;

  localparam longint BUS_WD_T1_NS = 64'd1_330_000;
  localparam longint BUS_WD_T2_NS = 64'd35_700_000;
  localparam longint BUS_WD_T3_NS = 64'd41_700_000;
  localparam longint BUS_WD_CYC1  = BUS_WD_T1_NS / CLK_PERIOD_NS;
  localparam longint BUS_WD_CYC2  = BUS_WD_T2_NS / CLK_PERIOD_NS;
  localparam longint BUS_WD_CYC3  = BUS_WD_T3_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // configuration load sequence
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    GWC_LOAD = 2'b01,
    GWC_RUN  = 2'b10
  } gwc_load_t;

endpackage : gwc_pkg

//--- shared/gwc_timer_if.sv
// control and expiry signals of one period timer
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none

interface gwc_timer_if;
  import gwc_pkg::*;

  logic             run;
  logic             clr;
  logic [TMR_W-1:0] limit;
  logic             expired;

  modport ctrl  (output run, output clr, output limit, input expired);
  modport timer (input run, input clr, input limit, output expired);

endinterface : gwc_timer_if

`default_nettype wire

//--- verif/gwc_host_model.sv
// host model: issues one-cycle register strobes just after a rising edge
// assumes the block takes a strobe at the rising edge where it is high
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// host model
// ---------------------------------------------------------------------
module gwc_host_model
  import gwc_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic [gwc_pkg::REG_W-1:0]  regRdData,
  output var  logic                       regWrEn,
  output var  logic                       regRdEn,
  output var  logic [gwc_pkg::ADDR_W-1:0] regAddr,
  output var  logic [gwc_pkg::REG_W-1:0]  regWrData
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge sys_clk);
    #1;
    regWrEn = w;
    regRdEn = !w;
    regAddr = a;
    regWrData = d;
    @(posedge sys_clk);
    #1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    // released lines show the inverse so a stale value never looks live
    regAddr = ~a;
    regWrData = ~d;
  endtask : xfer
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
    xfer(1'b0, a, RD_ZERO);
    @(posedge sys_clk);
    #1;
    d = regRdData;
  endtask : rd
  // restart the count before each change of the period
  task automatic setCfg(input logic [REG_W-1:0] d);
    wr(ADDR_CFG_THREE, {6'h00, CLR_CMD});
    wr(ADDR_CFG_TWO, d | 8'h10);
  endtask : setCfg
endmodule : gwc_host_model
`default_nettype wire

//--- verif/gwc_top_sva.sv
// port checker for the global configuration and watchdog block
// assumes one clock domain and timer lengths of at least ten cycles
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// checker
// ---------------------------------------------------------------------
module gwc_top_sva
  import gwc_pkg::*;
#(
  parameter logic [gwc_pkg::TMR_W-1:0] SYS_WD_CYC_0 = 36'h14,
  parameter logic [gwc_pkg::TMR_W-1:0] BUS_WD_CYC_1 = 36'ha
) (
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  input wire logic                       regWrEn,
  input wire logic [gwc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [gwc_pkg::REG_W-1:0]  regWrData,
  input wire logic                       busActive,
  input wire logic                       busWdTimeout,
  input wire logic                       gpioZeroAltIn,
  input wire logic                       powerOffStart,
  input wire logic                       globalShutdown,
  input wire logic                       globalLowPower,
  input wire logic                       sysWdTimeout,
  input wire logic                       sysWdRunning
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] gapCnt_q;
  logic [7:0] busRun_q;
  // saturating counters: only the short bench lengths are judged exactly
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) gapCnt_q <= 8'hff;
    else if (sysWdTimeout) gapCnt_q <= 8'h00;
    else if (gapCnt_q != 8'hff) gapCnt_q <= gapCnt_q + 8'h01;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) busRun_q <= 8'h00;
    else if (!busActive) busRun_q <= 8'h00;
    else if (busRun_q != 8'hff) busRun_q <= busRun_q + 8'h01;
  end
  property p_pinLowPower;
    gpioZeroAltIn [*4] |-> globalLowPower;
  endproperty
  a_pinLowPower: assert property (p_pinLowPower) else $error("pin high, low-power low");
  property p_idleNoExpiry;
    !sysWdRunning [*4] |-> !sysWdTimeout;
  endproperty
  a_idleNoExpiry: assert property (p_idleNoExpiry) else $error("expiry while stopped");
  property p_powerOffStop;
    powerOffStart |-> ##[1:3] !sysWdRunning;
  endproperty
  a_powerOffStop: assert property (p_powerOffStop) else $error("runs after power-off");
  property p_shutdownStop;
    globalShutdown |-> ##[1:3] !sysWdRunning;
  endproperty
  a_shutdownStop: assert property (p_shutdownStop) else $error("runs after shutdown");
  property p_expiryGap;
    sysWdTimeout |-> {28'h0, gapCnt_q} >= SYS_WD_CYC_0 - 36'h1;
  endproperty
  a_expiryGap: assert property (p_expiryGap) else $error("expiry gap too short");
  property p_expiryPulse;
    sysWdTimeout |=> !sysWdTimeout;
  endproperty
  a_expiryPulse: assert property (p_expiryPulse) else $error("expiry not one cycle");
  property p_busNeedsActivity;
    busWdTimeout |-> {28'h0, busRun_q} + 36'h2 >= BUS_WD_CYC_1;
  endproperty
  a_busNeedsActivity: assert property (p_busNeedsActivity) else $error("bus expiry early");
  property p_clearRestarts;
    regWrEn && regAddr == ADDR_CFG_THREE && regWrData[1:0] == CLR_CMD && !globalShutdown
      |-> ##4 !sysWdTimeout [*8];
  endproperty
  a_clearRestarts: assert property (p_clearRestarts) else $error("expiry soon after clear");
  c_sysExpiry: cover property (sysWdTimeout);
  c_busExpiry: cover property (busWdTimeout);
  c_powerOff: cover property (powerOffStart ##1 !sysWdRunning);
endmodule : gwc_top_sva
bind gwc_top gwc_top_sva #(.SYS_WD_CYC_0(SYS_WD_CYC_0), .BUS_WD_CYC_1(BUS_WD_CYC_1)) i_gwc_top_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regAddr(regAddr),
  .regWrData(regWrData), .busActive(busActive), .busWdTimeout(busWdTimeout),
  .gpioZeroAltIn(gpioZeroAltIn), .powerOffStart(powerOffStart),
  .globalShutdown(globalShutdown), .globalLowPower(globalLowPower),
  .sysWdTimeout(sysWdTimeout), .sysWdRunning(sysWdRunning));
`default_nettype wire

//--- verif/gwc_top_tb.sv
// self-checking bench for the global configuration and watchdog block
// assumes shortened timer lengths; straps change only while in reset
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// bench
// ---------------------------------------------------------------------
module gwc_top_tb;
  import gwc_pkg::*;
  localparam logic [TMR_W-1:0] SC [4] = '{36'd20, 36'd40, 36'd60, 36'd80};
  localparam logic [TMR_W-1:0] BC1 = 36'd10;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrEn, regRdEn, busActive = 1'b0, busWdTimeout, gpioZeroAltIn = 1'b0;
  logic sleepState = 1'b0, powerOffStart = 1'b0, globalShutdown = 1'b0;
  logic otpEnableLock = 1'b0, otpPeriodLock = 1'b0, otpEnableDefault = 1'b0;
  logic globalLowPower, sysWdTimeout, sysWdRunning;
  logic [ADDR_W-1:0] regAddr;
  logic [REG_W-1:0] regWrData, regRdData, d, v;
  int n_mismatch = 0;
  int check_count = 0;
  int n;
  int seed;
  always #2 sys_clk = ~sys_clk;
  // longer bus codes keep their full length, so the bench only sees them stay quiet
  gwc_top #(.SYS_WD_CYC_0(SC[0]), .SYS_WD_CYC_1(SC[1]), .SYS_WD_CYC_2(SC[2]),
    .SYS_WD_CYC_3(SC[3]), .BUS_WD_CYC_1(BC1))
  i_gwc_top (.sys_clk(sys_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .busActive(busActive),
    .busWdTimeout(busWdTimeout), .gpioZeroAltIn(gpioZeroAltIn), .sleepState(sleepState),
    .powerOffStart(powerOffStart), .globalShutdown(globalShutdown),
    .otpEnableLock(otpEnableLock), .otpPeriodLock(otpPeriodLock),
    .otpEnableDefault(otpEnableDefault), .globalLowPower(globalLowPower),
    .sysWdTimeout(sysWdTimeout), .sysWdRunning(sysWdRunning));
  gwc_host_model i_gwc_host_model (.sys_clk(sys_clk), .regRdData(regRdData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
  // bit 4 is not stored and reads as zero
  function automatic logic [REG_W-1:0] expRead(input logic [REG_W-1:0] w);
    return w & 8'hef;
  endfunction : expRead
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  // counts cycles up to the next expiry pulse; a required pulse that never comes ends the run
  task automatic waitPulse(input bit bus, input bit must, input int maxN, output int c);
    c = 0;
    do begin
      tick(1);
      c++;
    end while (c < maxN && (bus ? busWdTimeout : sysWdTimeout) !== 1'b1);
    if (must && c == maxN) begin
      n_mismatch++;
      stop_test();
    end
  endtask : waitPulse
  initial begin
    seed = 32'h478aac7a;
    tick(16);
    rst_n = 1'b1;
    i_gwc_host_model.rd(ADDR_CFG_TWO, d);
    check("cfg two reset", d, 8'h03);
    i_gwc_host_model.rd(ADDR_CFG_THREE, d);
    check("cfg three reset", d, 8'h00);
    i_gwc_host_model.rd(8'h07, d);
    check("unmapped read", d, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed)) | 8'h10;
      i_gwc_host_model.setCfg(v);
      i_gwc_host_model.rd(ADDR_CFG_TWO, d);
      check("cfg two random", d, expRead(v));
    end
    i_gwc_host_model.setCfg(8'h20);
    tick(3);
    check("low power bit", globalLowPower, 1'b1);
    i_gwc_host_model.setCfg(8'h00);
    tick(3);
    check("low power off", globalLowPower, 1'b0);
    gpioZeroAltIn = 1'b1;
    tick(5);
    check("low power pin", globalLowPower, 1'b1);
    gpioZeroAltIn = 1'b0;
    tick(5);
    check("low power pin off", globalLowPower, 1'b0);
    waitPulse(1'b0, 1'b0, 100, n);
    check("disabled no expiry", n, 100);
    check("disabled running", sysWdRunning, 1'b0);
    for (int c = 0; c < 4; c++) begin
      i_gwc_host_model.setCfg(8'h04 | 8'(c));
      waitPulse(1'b0, 1'b1, 400, n);
      waitPulse(1'b0, 1'b1, 400, n);
      check("sys period", n, SC[c]);
    end
    i_gwc_host_model.setCfg(8'h04);
    waitPulse(1'b0, 1'b1, 400, n);
    tick(8);
    i_gwc_host_model.wr(ADDR_CFG_THREE, 8'h01);
    waitPulse(1'b0, 1'b1, 400, n);
    check("clear restarts", n > 15, 1);
    i_gwc_host_model.rd(ADDR_CFG_THREE, d);
    check("clear returns", d, 8'h00);
    waitPulse(1'b0, 1'b1, 400, n);
    tick(8);
    i_gwc_host_model.wr(ADDR_CFG_THREE, 8'h02);
    waitPulse(1'b0, 1'b1, 400, n);
    check("code 10 no clear", n <= 12, 1);
    i_gwc_host_model.rd(ADDR_CFG_THREE, d);
    check("code 10 kept", d, 8'h02);
    i_gwc_host_model.setCfg(8'h0c);
    sleepState = 1'b1;
    waitPulse(1'b0, 1'b0, 60, n);
    check("sleep clears", n, 60);
    i_gwc_host_model.setCfg(8'h04);
    waitPulse(1'b0, 1'b1, 60, n);
    check("sleep no clear", n < 60, 1);
    sleepState = 1'b0;
    for (int c = 0; c < 4; c++) begin
      i_gwc_host_model.setCfg(8'(c) << 6);
      busActive = 1'b1;
      waitPulse(1'b1, c == 1, 40, n);
      busActive = 1'b0;
      tick(2);
      check("bus period", c == 1 ? (n + 1 >= BC1 && n <= BC1 + 2) : n == 40, 1);
    end
    i_gwc_host_model.setCfg(8'h04);
    tick(3);
    powerOffStart = 1'b1;
    tick(1);
    powerOffStart = 1'b0;
    tick(3);
    check("power off stops", sysWdRunning, 1'b0);
    i_gwc_host_model.rd(ADDR_CFG_TWO, d);
    check("enable kept", d, 8'h04);
    globalShutdown = 1'b1;
    tick(1);
    globalShutdown = 1'b0;
    i_gwc_host_model.rd(ADDR_CFG_TWO, d);
    check("shutdown cfg two", d, 8'h03);
    i_gwc_host_model.rd(ADDR_CFG_THREE, d);
    check("shutdown cfg three", d, 8'h00);
    rst_n = 1'b0;
    otpEnableLock = 1'b1;
    otpPeriodLock = 1'b1;
    otpEnableDefault = 1'b1;
    tick(16);
    rst_n = 1'b1;
    i_gwc_host_model.rd(ADDR_CFG_TWO, d);
    check("strap default", d, 8'h07);
    check("strap running", sysWdRunning, 1'b1);
    i_gwc_host_model.setCfg(8'h10);
    i_gwc_host_model.rd(ADDR_CFG_TWO, d);
    check("locked fields", d, 8'h07);
    waitPulse(1'b0, 1'b1, 400, n);
    waitPulse(1'b0, 1'b1, 400, n);
    check("locked period", n, SC[3]);
    stop_test();
  end
endmodule : gwc_top_tb
`default_nettype wire

//--- verilog/gwc_period_timer.sv
// free-running period timer with clear and one-cycle expiry pulse
// assumes limit is at least one and stable while run is high
`timescale 1ns/1ps
`default_nettype none

module gwc_period_timer (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  gwc_timer_if.timer tif
);
  import gwc_pkg::*;

  logic [TMR_W-1:0] count_q;
  logic             hit;

  // count restarts after each expiry so a missed service keeps firing
  assign hit = (count_q >= (tif.limit - TMR_W'(1)));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q     <= '0;
      tif.expired <= 1'b0;
    end else if (!tif.run || tif.clr) begin
      count_q     <= '0;
      tif.expired <= 1'b0;
    end else if (hit) begin
      count_q     <= '0;
      tif.expired <= 1'b1;
    end else begin
      count_q     <= count_q + TMR_W'(1);
      tif.expired <= 1'b0;
    end
  end

endmodule : gwc_period_timer

`default_nettype wire

//--- verilog/gwc_sync2.sv
// two-flop synchroniser for one level
// assumes the input may change at any time relative to sys_clk
`timescale 1ns/1ps
`default_nettype none

module gwc_sync2 (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);

  logic meta_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : gwc_sync2

`default_nettype wire

//--- verilog/gwc_top.sv
// global configuration registers, bus watchdog and system watchdog
// assumes the serial bus decoder presents one-cycle read and write strobes,
// and that shutdown, sleep and power-off levels come from logic on sys_clk
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - bus watchdog code 00 off; 01,10,11 give 1.33, 35.7, 41.7 ms.
// - low-power bit high drives global low-power signal high, else the synchronised pin-zero input decides.
// - global low-power signal is register bit OR pin-zero alternate input.
// - sleep auto-clear bit set clears watchdog count while in sleep.
// - system watchdog runs only while its enable bit is one.
// - with enable lock, a set enable cannot be cleared until shutdown.
// - system watchdog period codes give 2, 16, 64, 128 seconds.
// - with period lock, period writes are taken only while disabled.
// - writing 01 to clear field restarts count; other codes are stored but do not restart it.
// - clear field returns to 00 by itself after a 01 write.
// - power-off start also stops the running system watchdog.
module gwc_top #(
  parameter logic [gwc_pkg::TMR_W-1:0] SYS_WD_CYC_0 = gwc_pkg::TMR_W'(gwc_pkg::SYS_WD_CYC0),
  parameter logic [gwc_pkg::TMR_W-1:0] SYS_WD_CYC_1 = gwc_pkg::TMR_W'(gwc_pkg::SYS_WD_CYC1),
  parameter logic [gwc_pkg::TMR_W-1:0] SYS_WD_CYC_2 = gwc_pkg::TMR_W'(gwc_pkg::SYS_WD_CYC2),
  parameter logic [gwc_pkg::TMR_W-1:0] SYS_WD_CYC_3 = gwc_pkg::TMR_W'(gwc_pkg::SYS_WD_CYC3),
  parameter logic [gwc_pkg::TMR_W-1:0] BUS_WD_CYC_1 = gwc_pkg::TMR_W'(gwc_pkg::BUS_WD_CYC1),
  parameter logic [gwc_pkg::TMR_W-1:0] BUS_WD_CYC_2 = gwc_pkg::TMR_W'(gwc_pkg::BUS_WD_CYC2),
  parameter logic [gwc_pkg::TMR_W-1:0] BUS_WD_CYC_3 = gwc_pkg::TMR_W'(gwc_pkg::BUS_WD_CYC3)
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        regWrEn,
  input  wire logic                        regRdEn,
  input  wire logic [gwc_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [gwc_pkg::REG_W-1:0]   regWrData,
  output var  logic [gwc_pkg::REG_W-1:0]   regRdData,
  input  wire logic                        busActive,
  output var  logic                        busWdTimeout,
  input  wire logic                        gpioZeroAltIn,
  input  wire logic                        sleepState,
  input  wire logic                        powerOffStart,
  input  wire logic                        globalShutdown,
  input  wire logic                        otpEnableLock,
  input  wire logic                        otpPeriodLock,
  input  wire logic                        otpEnableDefault,
  output var  logic                        globalLowPower,
  output var  logic                        sysWdTimeout,
  output var  logic                        sysWdRunning
);
  import gwc_pkg::*;

  // ---------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------
  gwc_load_t        loadState_q;
  logic [1:0]       busWdPeriod_q;
  logic             lowPowerBit_q;
  logic             sleepAutoClear_q;
  logic             sysWdEnable_q;
  logic             sysWdEnable_d;
  logic [1:0]       sysWdPeriod_q;
  logic [1:0]       sysWdPeriod_d;
  logic [1:0]       sysWdClear_q;
  logic             powerOffSeen_q;
  logic             clrPulse_q;
  logic             gpioZeroSync;
  logic             loadNow;
  logic             wrCfgTwo;
  logic             wrCfgThree;
  logic [1:0]       wrBusPeriod;
  logic             wrEnable;
  logic [1:0]       wrPeriod;
  logic [1:0]       wrClear;
  logic [TMR_W-1:0] sysLimit;
  logic [TMR_W-1:0] busLimit;

  gwc_timer_if sysTmr ();
  gwc_timer_if busTmr ();

  // ---------------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------------
  // other addresses match neither decode, so their writes are dropped
  assign wrCfgTwo    = regWrEn && (regAddr == ADDR_CFG_TWO);
  assign wrCfgThree  = regWrEn && (regAddr == ADDR_CFG_THREE);
  assign wrBusPeriod = regWrData[BUS_WD_LSB +: 2];
  assign wrEnable    = regWrData[EN_BIT];
  assign wrPeriod    = regWrData[PER_LSB +: 2];
  assign wrClear     = regWrData[CLR_LSB +: 2];

  // defaults load in the first cycle after reset release and on shutdown
  assign loadNow = (loadState_q == GWC_LOAD) || globalShutdown;

  // ---------------------------------------------------------------------
  // load sequence
  // ---------------------------------------------------------------------
  // the lock straps are only read once reset has gone, never under it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loadState_q <= GWC_LOAD;
    end else begin
      case (loadState_q)
        GWC_LOAD: loadState_q <= GWC_RUN;
        GWC_RUN:  loadState_q <= GWC_RUN;
        default:  loadState_q <= GWC_LOAD;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------------
  // the pin is asynchronous, so it passes two flops before any use
  gwc_sync2 u_gpio_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (gpioZeroAltIn),
    .q       (gpioZeroSync)
  );

  // ---------------------------------------------------------------------
  // plain configuration fields
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busWdPeriod_q    <= BUS_WD_RST;
      lowPowerBit_q    <= LPM_RST;
      sleepAutoClear_q <= SLPC_RST;
    end else if (loadNow) begin
      busWdPeriod_q    <= BUS_WD_RST;
      lowPowerBit_q    <= LPM_RST;
      sleepAutoClear_q <= SLPC_RST;
    end else if (wrCfgTwo) begin
      busWdPeriod_q    <= wrBusPeriod;
      lowPowerBit_q    <= regWrData[LPM_BIT];
      sleepAutoClear_q <= regWrData[SLPC_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // watchdog enable and period with lock straps
  // ---------------------------------------------------------------------
  always_comb begin
    sysWdEnable_d = sysWdEnable_q;
    sysWdPeriod_d = sysWdPeriod_q;
    if (wrCfgTwo) begin
      // a locked, already set enable ignores a clearing write
      if (!(otpEnableLock && sysWdEnable_q)) begin
        sysWdEnable_d = wrEnable;
      end
      // period is judged against the enable before this write
      if (!(otpPeriodLock && sysWdEnable_q)) begin
        sysWdPeriod_d = wrPeriod;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysWdEnable_q <= EN_RST;
      sysWdPeriod_q <= PER_RST;
    end else if (loadNow) begin
      sysWdEnable_q <= otpEnableDefault;
      sysWdPeriod_q <= PER_RST;
    end else begin
      sysWdEnable_q <= sysWdEnable_d;
      sysWdPeriod_q <= sysWdPeriod_d;
    end
  end

  // ---------------------------------------------------------------------
  // clear field and command
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysWdClear_q <= CLR_RST;
    end else if (loadNow) begin
      sysWdClear_q <= CLR_RST;
    end else if (wrCfgThree) begin
      sysWdClear_q <= wrClear;
    end else if (sysWdClear_q == CLR_CMD) begin
      sysWdClear_q <= CLR_IDLE;
    end
  end

  // only the exact command code restarts the count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clrPulse_q <= 1'b0;
    end else begin
      clrPulse_q <= wrCfgThree && (wrClear == CLR_CMD) && !loadNow;
    end
  end

  // ---------------------------------------------------------------------
  // power-off stop
  // ---------------------------------------------------------------------
  // held until shutdown; software cannot restart a watchdog that power-off stopped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerOffSeen_q <= 1'b0;
    end else if (powerOffStart) begin
      powerOffSeen_q <= 1'b1;
    end else if (globalShutdown) begin
      powerOffSeen_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // system watchdog timer
  // ---------------------------------------------------------------------
  // a shorter code can expire at once on an old count; clear first
  always_comb begin
    case (sysWdPeriod_q)
      2'h0:    sysLimit = SYS_WD_CYC_0;
      2'h1:    sysLimit = SYS_WD_CYC_1;
      2'h2:    sysLimit = SYS_WD_CYC_2;
      default: sysLimit = SYS_WD_CYC_3;
    endcase
  end

  // held low while loading, so every shutdown restarts the count
  assign sysTmr.run   = sysWdEnable_q && !powerOffSeen_q && !loadNow;
  assign sysTmr.clr   = clrPulse_q || (sleepAutoClear_q && sleepState);
  assign sysTmr.limit = sysLimit;

  gwc_period_timer u_sys_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tif     (sysTmr)
  );

  // ---------------------------------------------------------------------
  // bus watchdog timer
  // ---------------------------------------------------------------------
  always_comb begin
    case (busWdPeriod_q)
      2'h1:    busLimit = BUS_WD_CYC_1;
      2'h2:    busLimit = BUS_WD_CYC_2;
      2'h3:    busLimit = BUS_WD_CYC_3;
      default: busLimit = BUS_WD_CYC_3;
    endcase
  end

  // a stalled transfer is timed only while it lasts; idle bus never fires
  assign busTmr.run   = busActive && (busWdPeriod_q != BUS_WD_OFF);
  // a register access shows the bus still moves, so the stall count restarts
  assign busTmr.clr   = regWrEn || regRdEn;
  assign busTmr.limit = busLimit;

  gwc_period_timer u_bus_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tif     (busTmr)
  );

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  // registered, so followers never see a decode glitch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      globalLowPower <= 1'b0;
    end else begin
      globalLowPower <= lowPowerBit_q || gpioZeroSync;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysWdTimeout <= 1'b0;
      busWdTimeout <= 1'b0;
      sysWdRunning <= 1'b0;
    end else begin
      sysWdTimeout <= sysTmr.expired;
      busWdTimeout <= busTmr.expired;
      sysWdRunning <= sysTmr.run;
    end
  end

  // ---------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------
  // reserved bits read as zero; software must not rely on bit 4
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= RD_ZERO;
    end else if (regRdEn) begin
      if (regAddr == ADDR_CFG_TWO) begin
        regRdData <= {busWdPeriod_q, lowPowerBit_q, 1'b0,
                      sleepAutoClear_q, sysWdEnable_q, sysWdPeriod_q};
      end else if (regAddr == ADDR_CFG_THREE) begin
        regRdData <= {6'h00, sysWdClear_q};
      end else begin
        regRdData <= RD_ZERO;
      end
    end
  end

endmodule : gwc_top

`default_nettype wire
